//--- link_mux_clock_monitor_maintenance_regs_test.sv
module link_mux_clock_monitor_maintenance_regs_test;
  import lmm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; lmm_byte_t w; lmm_byte_t e;} lmm_row_t;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cell_accept_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic cell_in_clock_i, cell_out_clock_i, reference_clock_in_i;
  logic hs_link_clock_i, synth_clock_i, cell_if_select_i;
  logic in_port_master_sel_i, ext_addr_proto_sel_i, out_port_master_sel_i;
  logic out_bus8_sel_i, serial_rx_pend_i, cell_addr_valid_i;
  logic [1:0] link_code_pend_i, fifo_pend_i, fifo_status_rd_i, rx_pair_i;
  logic [1:0] tx_data_i, remote_loop_req_i, los_i, lcd_i, rx_data_o;
  logic [1:0] rx_clk_from_tx_o, tx_pair_o, tx_pair_oe_o, defect_word_send_o;
  logic [10:0] cell_ext_addr_i;
  logic [15:0] out_prepend_o;
  logic out_prepend_en_o, irq_out_n_o, irq_out_oe_o;
  int fails, n_compared;
  lmm_row_t rows [8] = '{'{8'h04, 8'hff, 8'h04}, '{8'h14, 8'ha5, 8'ha5},
    '{8'h18, 8'h5a, 8'h5a}, '{8'h1c, 8'hff, 8'h07}, '{8'h20, 8'hff, 8'hff},
    '{8'h24, 8'hfe, 8'h06}, '{8'h40, 8'hff, 8'h00}, '{8'h10, 8'h1f, 8'h10}};
  lmm_regs u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cell_in_clock_i,
    .cell_out_clock_i, .reference_clock_in_i, .hs_link_clock_i,
    .synth_clock_i, .cell_if_select_i, .in_port_master_sel_i,
    .ext_addr_proto_sel_i, .out_port_master_sel_i, .out_bus8_sel_i,
    .link_code_pend_i, .serial_rx_pend_i, .fifo_pend_i, .fifo_status_rd_i,
    .rx_pair_i, .tx_data_i, .remote_loop_req_i, .los_i, .lcd_i,
    .cell_addr_valid_i, .cell_ext_addr_i, .rx_data_o, .rx_clk_from_tx_o,
    .tx_pair_o, .tx_pair_oe_o, .defect_word_send_o, .cell_accept_o,
    .out_prepend_o, .out_prepend_en_o, .irq_out_n_o, .irq_out_oe_o);
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Shared tasks
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Holds the request until ack is sampled, then idles one cycle
  task automatic xfer(input logic [7:0] a, input logic w, input lmm_byte_t d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_sel_i <= 4'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      end_of_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input lmm_byte_t e);
    xfer(a, 1'b0, 8'h00);
    chk(q, {24'h0, e});
  endtask : rd_chk
  task automatic pulse_clocks();
    cell_in_clock_i <= 1'b1;
    cell_out_clock_i <= 1'b1;
    reference_clock_in_i <= 1'b1;
    tick(3);
    cell_in_clock_i <= 1'b0;
    cell_out_clock_i <= 1'b0;
    reference_clock_in_i <= 1'b0;
    tick(6);
  endtask : pulse_clocks
  // Slow rising edges on the reference (bit 0) and link (bit 1) clocks
  task automatic slow_rises(input logic [1:0] which, input int n);
    repeat (n) begin
      reference_clock_in_i <= which[0];
      hs_link_clock_i <= which[1];
      tick(2);
      reference_clock_in_i <= 1'b0;
      hs_link_clock_i <= 1'b0;
      tick(2);
    end
  endtask : slow_rises
  // ==========================================================
  // Main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    rst_i <= 1'b1;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'h1;
    wb_dat_i <= 32'h0;
    cell_in_clock_i <= 1'b0;
    cell_out_clock_i <= 1'b0;
    reference_clock_in_i <= 1'b0;
    hs_link_clock_i <= 1'b0;
    synth_clock_i <= 1'b0;
    cell_if_select_i <= 1'b1;
    in_port_master_sel_i <= 1'b0;
    ext_addr_proto_sel_i <= 1'b1;
    out_port_master_sel_i <= 1'b0;
    out_bus8_sel_i <= 1'b0;
    link_code_pend_i <= 2'b00;
    serial_rx_pend_i <= 1'b0;
    fifo_pend_i <= 2'b00;
    fifo_status_rd_i <= 2'b00;
    rx_pair_i <= 2'b01;
    tx_data_i <= 2'b10;
    remote_loop_req_i <= 2'b00;
    los_i <= 2'b00;
    lcd_i <= 2'b00;
    cell_addr_valid_i <= 1'b0;
    cell_ext_addr_i <= 11'h534;
    tick(6);
    rst_i <= 1'b0;
    tick(2);
    chk(tx_pair_oe_o, 2'b11);
    foreach (rows[i]) rd_chk(rows[i].a, 8'h00);
    foreach (rows[i]) begin
      xfer(rows[i].a, 1'b1, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    xfer(8'h04, 1'b1, 8'h00);
    xfer(8'h14, 1'b1, 8'h03);
    tick(5);
    chk(rx_clk_from_tx_o, 2'b11);
    chk(rx_data_o, 2'b10);
    xfer(8'h14, 1'b1, 8'h1c);
    tick(5);
    chk(tx_pair_o, 2'b01);
    chk(tx_pair_oe_o, 2'b10);
    xfer(8'h14, 1'b1, 8'h00);
    remote_loop_req_i <= 2'b10;
    rx_pair_i <= 2'b11;
    tick(6);
    chk(tx_pair_o, 2'b10);
    // No manual defect word: no register write sends it, only LOS or LCD here
    remote_loop_req_i <= 2'b00;
    los_i <= 2'b01;
    lcd_i <= 2'b10;
    tick(3);
    chk(defect_word_send_o, 2'b11);
    xfer(8'h14, 1'b1, 8'h40);
    tick(2);
    chk(defect_word_send_o, 2'b10);
    los_i <= 2'b00;
    lcd_i <= 2'b00;
    xfer(8'h14, 1'b1, 8'h00);
    pulse_clocks();
    rd_chk(8'h10, 8'h17);
    rd_chk(8'h10, 8'h10);
    serial_rx_pend_i <= 1'b1;
    fifo_pend_i <= 2'b10;
    tick(1);
    serial_rx_pend_i <= 1'b0;
    fifo_pend_i <= 2'b00;
    link_code_pend_i <= 2'b10;
    tick(2);
    rd_chk(8'h0c, 8'h0e);
    rd_chk(8'h0c, 8'h0a);
    fifo_status_rd_i <= 2'b01;
    tick(1);
    fifo_status_rd_i <= 2'b00;
    tick(1);
    rd_chk(8'h0c, 8'h02);
    chk(irq_out_oe_o, 1'b0);
    xfer(8'h04, 1'b1, 8'h04);
    tick(2);
    chk({irq_out_oe_o, irq_out_n_o}, 2'b10);
    link_code_pend_i <= 2'b00;
    tick(3);
    chk(irq_out_oe_o, 1'b0);
    xfer(8'h18, 1'b1, 8'h34);
    xfer(8'h1c, 1'b1, 8'h05);
    xfer(8'h24, 1'b1, 8'h07);
    cell_addr_valid_i <= 1'b1;
    tick(3);
    chk(cell_accept_o, 1'b1);
    chk(out_prepend_o, {11'h534, 5'h00});
    cell_ext_addr_i <= 11'h535;
    tick(3);
    chk(cell_accept_o, 1'b0);
    xfer(8'h20, 1'b1, 8'hfe);
    tick(2);
    chk(cell_accept_o, 1'b1);
    xfer(8'h18, 1'b1, 8'h33);
    tick(2);
    chk(cell_accept_o, 1'b0);
    in_port_master_sel_i <= 1'b1;
    xfer(8'h18, 1'b1, 8'h35);
    tick(4);
    chk(cell_accept_o, 1'b0);
    in_port_master_sel_i <= 1'b0;
    ext_addr_proto_sel_i <= 1'b0;
    tick(6);
    chk(cell_accept_o, 1'b0);
    ext_addr_proto_sel_i <= 1'b1;
    tick(6);
    chk(cell_accept_o, 1'b1);
    out_port_master_sel_i <= 1'b1;
    tick(6);
    chk(out_prepend_en_o, 1'b0);
    out_port_master_sel_i <= 1'b0;
    out_bus8_sel_i <= 1'b1;
    tick(6);
    chk({out_prepend_en_o, out_prepend_o},
        {1'b1, 8'h00, 3'h5, 5'h00});
    // Serial mode: the parallel clock is ignored, link clock over six counts
    cell_if_select_i <= 1'b0;
    tick(4);
    rd_chk(8'h10, 8'h10);
    cell_in_clock_i <= 1'b1;
    slow_rises(2'b10, 2);
    cell_in_clock_i <= 1'b0;
    rd_chk(8'h10, 8'h10);
    slow_rises(2'b10, 1);
    rd_chk(8'h10, 8'h11);
    slow_rises(2'b10, 3);
    rd_chk(8'h10, 8'h10);
    slow_rises(2'b10, 3);
    rd_chk(8'h10, 8'h11);
    // Lock window: one reference edge so far, no synthesized edges at all
    slow_rises(2'b01, 2046);
    rd_chk(8'h10, 8'h14);
    rd_chk(8'h0c, 8'h00);
    slow_rises(2'b01, 1);
    tick(2);
    chk(irq_out_oe_o, 1'b1);
    rd_chk(8'h10, 8'h1c);
    rd_chk(8'h0c, 8'h01);
    rd_chk(8'h0c, 8'h00);
    chk(irq_out_oe_o, 1'b0);
    end_of_test();
  end
endmodule : link_mux_clock_monitor_maintenance_regs_test

bind lmm_regs lmm_regs_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .in_port_master_sel_i, .ext_addr_proto_sel_i,
  .out_port_master_sel_i, .out_bus8_sel_i, .rx_pair_i, .remote_loop_req_i,
  .los_i, .lcd_i, .tx_pair_o, .tx_pair_oe_o, .defect_word_send_o,
  .cell_accept_o, .out_prepend_o, .out_prepend_en_o, .irq_out_n_o,
  .irq_out_oe_o);

//--- lmm_consts.svh
`ifndef LMM_CONSTS_SVH
`define LMM_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define LMM_IDX_MASTER_CFG 6'h01
`define LMM_IDX_MISC_IRQ 6'h03
`define LMM_IDX_CLK_MON 6'h04
`define LMM_IDX_MAINT 6'h05
`define LMM_IDX_XMATCH_LO 6'h06
`define LMM_IDX_XMATCH_HI 6'h07
`define LMM_IDX_XMASK_LO 6'h08
`define LMM_IDX_XMASK_HI 6'h09

// ==========================================================
// Field positions
`define LMM_CFG_MASTER_IRQ_EN 2
`define LMM_MISC_REF_CHANGE 0
`define LMM_MISC_CODE_SUM 1
`define LMM_MISC_SERIAL_SUM 2
`define LMM_MISC_FIFO_SUM 3
`define LMM_MON_IN_SEEN 0
`define LMM_MON_OUT_SEEN 1
`define LMM_MON_REF_SEEN 2
`define LMM_MON_UNLOCK 3
`define LMM_MON_IRQ_EN 4
`define LMM_MAINT_DIAG 0
`define LMM_MAINT_METAL 2
`define LMM_MAINT_FLOAT 4
`define LMM_MAINT_DEFECT_OFF 6

// ==========================================================
// Reset values
`define LMM_RST_BYTE 8'h00
`define LMM_RST_XADDR 11'h000

// ==========================================================
// Timing counts
`define LMM_SERIAL_DIV_HALF 2'h3
`define LMM_REF_WINDOW 12'h800
`define LMM_SYNTH_EXPECT 16'h4000
`define LMM_SYNTH_TOL 16'h0008
`define LMM_SYNTH_SAT 16'hffff

`endif

//--- lmm_pkg.sv
package lmm_pkg;
  typedef logic [10:0] lmm_xaddr_t;
  typedef logic [5:0] lmm_reg_idx_t;
  typedef logic [7:0] lmm_byte_t;
endpackage : lmm_pkg

//--- lmm_regs.sv
// What this block does
// (R1) Code summary bit is set while either link has an enabled code status.
// (R2) Serial receive summary sets on enabled status, clears on this read.
// (R3) Extract FIFO summary sets on enabled status, clears on FIFO read.
// (R4) Clock seen bits set on rising edge, monitor read clears all.
// (R5) Input seen bit tracks input clock, or link clock over six.
// (R6) Output seen bit sets on output cell clock rising edge.
// (R7) Reference seen bit sets on reference clock rising edge.
// (R8) Unlock is one when synthesized clock strays over 488 ppm off 8x ref.
// (R9) Unlock change with both enables drives the interrupt low.
// (R10) Diagnostic loopback clocks receive from transmit, feeds transmit data.
// (R11) Metallic loopback sends sliced receive data out the transmitter.
// (R12) Metallic loopback may also be requested by inband codes.
// (R13) Transmit float bit releases that link's output pair.
// (R14) Defect word goes out after LOS or LCD unless auto-off set.
// (R15) Software may send the defect word by writing zero code; here no write sends it, only LOS or LCD without auto-off.
// (R16) Input slave accepts cell when unmasked address bits match.
// (R17) Output slave inserts match bits into the prepend by format.
// (R18) Interrupt driven only with master enable and an enabled status.
// (R19) Unlock change bit sets on state change, clears on status read.
// (R20) Read data is captured first; same-cycle events stay pending.
//
// Added by the designer: the Wishbone interface to the registers.
`include "lmm_consts.svh"

module lmm_regs
  import lmm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cell_in_clock_i,
  input wire logic cell_out_clock_i,
  input wire logic reference_clock_in_i,
  input wire logic hs_link_clock_i,
  input wire logic synth_clock_i,
  input wire logic cell_if_select_i,
  input wire logic in_port_master_sel_i,
  input wire logic ext_addr_proto_sel_i,
  input wire logic out_port_master_sel_i,
  input wire logic out_bus8_sel_i,
  input wire logic [1:0] link_code_pend_i,
  input wire logic serial_rx_pend_i,
  input wire logic [1:0] fifo_pend_i,
  input wire logic [1:0] fifo_status_rd_i,
  input wire logic [1:0] rx_pair_i,
  input wire logic [1:0] tx_data_i,
  input wire logic [1:0] remote_loop_req_i,
  input wire logic [1:0] los_i,
  input wire logic [1:0] lcd_i,
  input wire logic cell_addr_valid_i,
  input wire logic [10:0] cell_ext_addr_i,
  output logic [1:0] rx_data_o,
  output logic [1:0] rx_clk_from_tx_o,
  output logic [1:0] tx_pair_o,
  output logic [1:0] tx_pair_oe_o,
  output logic [1:0] defect_word_send_o,
  output logic cell_accept_o,
  output logic [15:0] out_prepend_o,
  output logic out_prepend_en_o,
  output logic irq_out_n_o,
  output logic irq_out_oe_o
);

  // ========================================================
  // Pin synchronisers
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;

  assign pin_raw = {rx_pair_i, out_bus8_sel_i, out_port_master_sel_i,
                    ext_addr_proto_sel_i, in_port_master_sel_i,
                    cell_if_select_i, synth_clock_i, hs_link_clock_i,
                    reference_clock_in_i, cell_out_clock_i,
                    cell_in_clock_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  // Rising edges seen from the second and third stages only
  logic in_rise, out_rise, ref_rise, hs_rise, synth_rise;
  logic if_sel, in_master, proto_sel, out_master, out_bus8;
  logic [1:0] rx_sync;
  assign in_rise = sync_b[0] & ~sync_c[0];
  assign out_rise = sync_b[1] & ~sync_c[1];
  assign ref_rise = sync_b[2] & ~sync_c[2];
  assign hs_rise = sync_b[3] & ~sync_c[3];
  assign synth_rise = sync_b[4] & ~sync_c[4];
  assign if_sel = sync_b[5];
  assign in_master = sync_b[6];
  assign proto_sel = sync_b[7];
  assign out_master = sync_b[8];
  assign out_bus8 = sync_b[9];
  assign rx_sync = sync_b[11:10];

  // ========================================================
  // Wishbone slave
  lmm_reg_idx_t idx;
  logic rd_fire;
  logic wr_fire;
  assign idx = wb_adr_i[7:2];
  assign rd_fire = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

  function automatic logic hit(input lmm_reg_idx_t a);
    hit = (idx == a);
  endfunction : hit

  logic rd_misc;
  logic rd_mon;
  assign rd_misc = rd_fire & hit(`LMM_IDX_MISC_IRQ);
  assign rd_mon = rd_fire & hit(`LMM_IDX_CLK_MON);

  // ========================================================
  // Software registers
  logic master_irq_en;
  logic ref_unlock_irq_en;
  lmm_byte_t maint;
  lmm_xaddr_t ext_addr_match;
  lmm_xaddr_t ext_addr_mask;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_irq_en <= 1'b0;
      ref_unlock_irq_en <= 1'b0;
      maint <= `LMM_RST_BYTE;
      ext_addr_match <= `LMM_RST_XADDR;
      ext_addr_mask <= `LMM_RST_XADDR;
    end else if (wr_fire) begin
      if (hit(`LMM_IDX_MASTER_CFG)) begin
        master_irq_en <= wb_dat_i[`LMM_CFG_MASTER_IRQ_EN];
      end
      if (hit(`LMM_IDX_CLK_MON)) begin
        ref_unlock_irq_en <= wb_dat_i[`LMM_MON_IRQ_EN];
      end
      if (hit(`LMM_IDX_MAINT)) begin
        maint <= wb_dat_i[7:0];
      end
      if (hit(`LMM_IDX_XMATCH_LO)) begin
        ext_addr_match[7:0] <= wb_dat_i[7:0];
      end
      if (hit(`LMM_IDX_XMATCH_HI)) begin
        ext_addr_match[10:8] <= wb_dat_i[2:0];
      end
      if (hit(`LMM_IDX_XMASK_LO)) begin
        ext_addr_mask[7:0] <= wb_dat_i[7:0];
      end
      if (hit(`LMM_IDX_XMASK_HI)) begin
        ext_addr_mask[10:8] <= wb_dat_i[2:0];
      end
    end
  end

  // ========================================================
  // Serial cell clock: link clock over six
  logic [1:0] div_cnt;
  logic serial_cell_clock;
  logic serial_rise;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 2'h0;
      serial_cell_clock <= 1'b0;
    end else if (hs_rise) begin
      if (div_cnt == `LMM_SERIAL_DIV_HALF - 2'h1) begin
        div_cnt <= 2'h0;
        serial_cell_clock <= ~serial_cell_clock; // see (R5)
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end
  assign serial_rise = hs_rise & ~serial_cell_clock &
                       (div_cnt == `LMM_SERIAL_DIV_HALF - 2'h1);

  // ========================================================
  // Clock activity monitor: set wins over the read clear
  logic in_clk_seen, out_clk_seen, ref_clk_seen;
  logic in_event;
  assign in_event = if_sel ? in_rise : serial_rise; // see (R5)

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_clk_seen <= 1'b0;
      out_clk_seen <= 1'b0;
      ref_clk_seen <= 1'b0;
    end else begin
      in_clk_seen <= in_event | (in_clk_seen & ~rd_mon); // see (R4)
      out_clk_seen <= out_rise | (out_clk_seen & ~rd_mon); // see (R6)
      ref_clk_seen <= ref_rise | (ref_clk_seen & ~rd_mon); // see (R7)
    end
  end

  // ========================================================
  // Lock check: synth edges over a window of reference edges.
  // Synth clock must be slow enough to sample at clk_i.
  logic [11:0] ref_cnt;
  logic [15:0] synth_cnt;
  logic ref_unlock_state;
  logic window_end;
  logic [15:0] synth_next;
  assign window_end = ref_rise & (ref_cnt == `LMM_REF_WINDOW - 12'h001);
  assign synth_next = (synth_rise && synth_cnt != `LMM_SYNTH_SAT) ?
                      synth_cnt + 16'h0001 : synth_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt <= 12'h000;
      synth_cnt <= 16'h0000;
      ref_unlock_state <= 1'b0;
    end else if (window_end) begin
      ref_cnt <= 12'h000;
      synth_cnt <= 16'h0000;
      ref_unlock_state <=
        (synth_next > `LMM_SYNTH_EXPECT + `LMM_SYNTH_TOL) ||
        (synth_next < `LMM_SYNTH_EXPECT - `LMM_SYNTH_TOL); // see (R8)
    end else begin
      if (ref_rise) begin
        ref_cnt <= ref_cnt + 12'h001;
      end
      synth_cnt <= synth_next;
    end
  end

  logic unlock_prev;
  logic ref_unlock_change;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_prev <= 1'b0;
      ref_unlock_change <= 1'b0;
    end else begin
      unlock_prev <= ref_unlock_state;
      ref_unlock_change <= (unlock_prev != ref_unlock_state) |
                           (ref_unlock_change & ~rd_misc); // see (R19) (R20)
    end
  end

  // ========================================================
  // Summary bits
  logic link_code_irq_summary;
  logic serial_rx_irq_summary;
  logic extract_fifo_irq_summary;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_code_irq_summary <= 1'b0;
      serial_rx_irq_summary <= 1'b0;
      extract_fifo_irq_summary <= 1'b0;
    end else begin
      link_code_irq_summary <= |link_code_pend_i; // see (R1)
      serial_rx_irq_summary <= serial_rx_pend_i |
        (serial_rx_irq_summary & ~rd_misc); // see (R2) (R20)
      extract_fifo_irq_summary <= (|fifo_pend_i) |
        (extract_fifo_irq_summary & ~(|fifo_status_rd_i)); // see (R3)
    end
  end

  // ========================================================
  // Read data captured from pre-clear values
  lmm_byte_t rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `LMM_IDX_MASTER_CFG: rd_byte[`LMM_CFG_MASTER_IRQ_EN] = master_irq_en;
      `LMM_IDX_MISC_IRQ: rd_byte = {4'h0, extract_fifo_irq_summary,
        serial_rx_irq_summary, link_code_irq_summary, ref_unlock_change};
      `LMM_IDX_CLK_MON: rd_byte = {3'h0, ref_unlock_irq_en, ref_unlock_state,
        ref_clk_seen, out_clk_seen, in_clk_seen};
      `LMM_IDX_MAINT: rd_byte = maint;
      `LMM_IDX_XMATCH_LO: rd_byte = ext_addr_match[7:0];
      `LMM_IDX_XMATCH_HI: rd_byte = {5'h00, ext_addr_match[10:8]};
      `LMM_IDX_XMASK_LO: rd_byte = ext_addr_mask[7:0];
      `LMM_IDX_XMASK_HI: rd_byte = {5'h00, ext_addr_mask[10:8]};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_fire) begin
        wb_dat_o <= {24'h00_0000, rd_byte}; // see (R20)
      end
    end
  end

  // ========================================================
  // Interrupt pin: open drain, only ever pulls low
  logic irq_cause;
  assign irq_cause = (ref_unlock_change & ref_unlock_irq_en) | // see (R9)
                     link_code_irq_summary | serial_rx_irq_summary |
                     extract_fifo_irq_summary;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_out_n_o <= 1'b0;
      irq_out_oe_o <= 1'b0;
    end else begin
      irq_out_n_o <= 1'b0;
      irq_out_oe_o <= master_irq_en & irq_cause; // see (R18)
    end
  end

  // ========================================================
  // Link loopbacks and defect word
  logic [1:0] diag_loop;
  logic [1:0] metal_loop;
  logic [1:0] tx_float;
  logic [1:0] defect_auto_off;
  assign diag_loop = maint[`LMM_MAINT_DIAG +: 2];
  assign metal_loop = maint[`LMM_MAINT_METAL +: 2] |
                      remote_loop_req_i; // see (R12)
  assign tx_float = maint[`LMM_MAINT_FLOAT +: 2];
  assign defect_auto_off = maint[`LMM_MAINT_DEFECT_OFF +: 2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_link
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rx_data_o[gi] <= 1'b0;
          rx_clk_from_tx_o[gi] <= 1'b0;
          tx_pair_o[gi] <= 1'b0;
          tx_pair_oe_o[gi] <= 1'b0;
          defect_word_send_o[gi] <= 1'b0;
        end else begin
          rx_clk_from_tx_o[gi] <= diag_loop[gi]; // see (R10)
          rx_data_o[gi] <= diag_loop[gi] ? tx_data_i[gi] : rx_sync[gi];
          tx_pair_o[gi] <= metal_loop[gi] ? rx_sync[gi] :
                           tx_data_i[gi]; // see (R11)
          tx_pair_oe_o[gi] <= ~tx_float[gi]; // see (R13)
          defect_word_send_o[gi] <= ~defect_auto_off[gi] &
                                    (los_i[gi] | lcd_i[gi]); // see (R14)
        end
      end
    end
  endgenerate

  // ========================================================
  // Extended address match for the cell interface
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_accept_o <= 1'b0;
      out_prepend_o <= 16'h0000;
      out_prepend_en_o <= 1'b0;
    end else begin
      cell_accept_o <= cell_addr_valid_i & proto_sel & ~in_master &
        (((cell_ext_addr_i ^ ext_addr_match) & ext_addr_mask) ==
         11'h000); // see (R16)
      out_prepend_en_o <= ~out_master;
      out_prepend_o <= out_bus8 ?
        {8'h00, ext_addr_match[2:0], 5'h00} :
        {ext_addr_match, 5'h00}; // see (R17)
    end
  end

endmodule : lmm_regs

//--- lmm_regs_checker.sv
module lmm_regs_checker
  import lmm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic in_port_master_sel_i,
  input wire logic ext_addr_proto_sel_i,
  input wire logic out_port_master_sel_i,
  input wire logic out_bus8_sel_i,
  input wire logic [1:0] rx_pair_i,
  input wire logic [1:0] remote_loop_req_i,
  input wire logic [1:0] los_i,
  input wire logic [1:0] lcd_i,
  input wire logic [1:0] tx_pair_o,
  input wire logic [1:0] tx_pair_oe_o,
  input wire logic [1:0] defect_word_send_o,
  input wire logic cell_accept_o,
  input wire logic [15:0] out_prepend_o,
  input wire logic out_prepend_en_o,
  input wire logic irq_out_n_o,
  input wire logic irq_out_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Bus handshake
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ONCE: assert property (s_taken |=> s_answer)
    else $error("ack is not one pulse one cycle after request");
  AST_READ_HIGH_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  // ==========================================================
  // Link, cell and interrupt side
  AST_REMOTE_LOOP: assert property (
    (remote_loop_req_i[1] && $stable(rx_pair_i[1])) [*5] |=>
    (!tx_pair_oe_o[1] || tx_pair_o[1] == $past(rx_pair_i[1])))
    else $error("remote loop does not return receive data");
  AST_DEFECT_CAUSE: assert property (
    defect_word_send_o[0] |-> $past(los_i[0]) || $past(lcd_i[0]))
    else $error("defect word without a defect");
  AST_ACCEPT_MODE: assert property (cell_accept_o |->
    $past(ext_addr_proto_sel_i, 3) && !$past(in_port_master_sel_i, 3))
    else $error("cell accepted outside input slave mode");
  AST_PREPEND_SLAVE: assert property (out_prepend_en_o |->
    !$past(out_port_master_sel_i, 3) && out_prepend_o[4:0] == 5'h00)
    else $error("prepend inserted outside slave mode");
  AST_PREPEND_NARROW: assert property (out_prepend_en_o &&
    $past(out_bus8_sel_i, 3) && $past(out_bus8_sel_i, 4) |->
    out_prepend_o[15:8] == 8'h00)
    else $error("narrow prepend has high bits set");
  AST_IRQ_LOW: assert property (irq_out_oe_o |-> !irq_out_n_o)
    else $error("interrupt driven but not low");
  AST_IRQ_RELEASE: assert property (
    $fell(irq_out_oe_o) |-> $stable(irq_out_n_o))
    else $error("interrupt level moved on release");
endmodule : lmm_regs_checker
